/* File: pkg/rti_consts.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the wakeup timer
// Assumes: Included by bare name from the package, the timer and the testbench
// Notes:   Definitions only
`ifndef RTI_CONSTS_SVH
`define RTI_CONSTS_SVH

// -----------------------------------------------------------------------------
// Register bus shape
// -----------------------------------------------------------------------------
`define RTI_ADDR_W          8
`define RTI_DATA_W          8

// -----------------------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------------------
`define RTI_OFF_CTRL        8'h00
`define RTI_OFF_IRQ_STAT    8'h01
`define RTI_OFF_IRQ_MASK    8'h02
`define RTI_OFF_CNT_LO      8'h03
`define RTI_OFF_CNT_HI      8'h04

// -----------------------------------------------------------------------------
// Control register fields and reset values
// -----------------------------------------------------------------------------
`define RTI_BIT_FLAG        7
`define RTI_BIT_ACK         6
`define RTI_BIT_CLKSEL      5
`define RTI_BIT_IE          4
`define RTI_PSEL_HI         2
`define RTI_PSEL_LO         0
`define RTI_CTRL_RESET      8'h00
`define RTI_PSEL_OFF        3'h0

// -----------------------------------------------------------------------------
// Event status and mask fields
// -----------------------------------------------------------------------------
`define RTI_IRQ_W           2
`define RTI_IRQ_TIMEOUT     0
`define RTI_IRQ_OVERRUN     1
`define RTI_IRQ_RESET       2'h0

// -----------------------------------------------------------------------------
// Timing
// -----------------------------------------------------------------------------
`define RTI_SYS_CLK_NS      10
`define RTI_TICK_NS         1000000
`define RTI_TICK_CYCLES     (`RTI_TICK_NS / `RTI_SYS_CLK_NS)
`define RTI_CNT_W           16

// Terminal counts with the internal 1 ms tick, codes 1 to 7
`define RTI_INT_CNT_1       16'h0008
`define RTI_INT_CNT_2       16'h0020
`define RTI_INT_CNT_3       16'h0040
`define RTI_INT_CNT_4       16'h0080
`define RTI_INT_CNT_5       16'h0100
`define RTI_INT_CNT_6       16'h0200
`define RTI_INT_CNT_7       16'h0400

// Terminal counts in external clock periods, codes 1 to 7
`define RTI_EXT_CNT_1       16'h0100
`define RTI_EXT_CNT_2       16'h0400
`define RTI_EXT_CNT_3       16'h0800
`define RTI_EXT_CNT_4       16'h1000
`define RTI_EXT_CNT_5       16'h2000
`define RTI_EXT_CNT_6       16'h4000
`define RTI_EXT_CNT_7       16'h8000

`endif

/* File: pkg/rti_pkg.sv */
// Purpose: Types shared by the wakeup timer files
// Assumes: rti_consts.svh on the include path
// Notes:   Numbers live in the header, types live here
`include "rti_consts.svh"

package rti_pkg;

  // One register byte
  typedef logic [`RTI_DATA_W-1:0] reg_byte_t;

  // Register address
  typedef logic [`RTI_ADDR_W-1:0] reg_addr_t;

  // Period select code
  typedef logic [`RTI_PSEL_HI:`RTI_PSEL_LO] period_sel_t;

  // Timer state, one-hot
  typedef enum logic [1:0] {
    ST_OFF = 2'b01,
    ST_RUN = 2'b10
  } rti_state_t;

endpackage

/* File: rtl/rti_sync.sv */
// Purpose: Two-flop synchroniser for a level from outside the clock domain
// Assumes: Input changes slower than the system clock
// Notes:   First stage is read by the second stage only
`timescale 1ns/10ps
`default_nettype none

module rti_sync (
  // Clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_rst,
  // Level in and out
  input  wire logic i_async,
  output logic      o_sync
);

  logic meta_q;

  // -----------------------------------------------------------------------------
  // Two stages
  // -----------------------------------------------------------------------------
  // Capture then settle
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      meta_q <= 1'b0;
      o_sync <= 1'b0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule

`default_nettype wire

/* File: rtl/rti_tick_div.sv */
// Purpose: Free running divider giving a one-cycle tick every CYCLES clocks
// Assumes: CYCLES is at least 2
// Notes:   Stands in for the internal 1 kHz oscillator
`timescale 1ns/10ps
`default_nettype none

module rti_tick_div #(
  parameter int unsigned CYCLES = 100000
) (
  // Clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_rst,
  // Tick out
  output logic      o_tick
);

  localparam int unsigned W = (CYCLES > 2) ? $clog2(CYCLES) : 1;
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);

  logic [W-1:0] cnt_q;

  // -----------------------------------------------------------------------------
  // Divider
  // -----------------------------------------------------------------------------
  // Wrap at the last count and pulse there
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cnt_q  <= '0;
      o_tick <= 1'b0;
    end else begin
      o_tick <= (cnt_q == LAST);
      if (cnt_q == LAST) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

/* File: rtl/rti_timer.sv */
// Purpose: Periodic wakeup timer with status and control register
// Assumes: External clock well below a quarter of the system clock
// Notes:   Registers on a plain strobe port, read data one cycle later
//
// Notes on behaviour
// RULE1 - timeout sets read-only flag bit 7
// RULE2 - writing one to bit 6 clears flag
// RULE3 - ack zero does nothing, reads zero
// RULE4 - bit 5 picks internal or external clock
// RULE5 - bit 4 gates the interrupt request
// RULE6 - bits 2:0 set period, zero disables
// RULE7 - internal periods 8 ms to 1.024 s
// RULE8 - external periods 256 to 32768 clocks
// RULE9 - first internal timeout may be short
// RULE10 - request while flag and enable set
// RULE11 - counter restarts after every timeout
`include "rti_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module rti_timer #(
  parameter int unsigned TICK_CYCLES = `RTI_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic               i_clk_sys,
  input  wire logic               i_rst,
  // Register port
  input  wire rti_pkg::reg_addr_t i_addr,
  input  wire rti_pkg::reg_byte_t i_wr_data,
  input  wire logic               i_wr,
  input  wire logic               i_rd,
  output rti_pkg::reg_byte_t      o_rd_data_q,
  // External timer clock pin
  input  wire logic               i_ext_clk,
  // Interrupts
  output logic                    o_rti_req_q,
  output logic                    o_irq_q
);

  import rti_pkg::*;

  // -----------------------------------------------------------------------------
  // Declarations
  // -----------------------------------------------------------------------------
  logic                   flag_q;
  logic                   clksel_q;
  logic                   ie_q;
  period_sel_t            psel_q;
  rti_state_t             state_q;
  rti_state_t             state_d;
  logic [`RTI_CNT_W-1:0]  cnt_q;
  logic [`RTI_CNT_W-1:0]  limit;
  logic [`RTI_IRQ_W-1:0]  stat_q;
  logic [`RTI_IRQ_W-1:0]  mask_q;
  logic [`RTI_IRQ_W-1:0]  stat_set;
  logic                   ext_sync;
  logic                   ext_prev_q;
  logic                   ext_rise;
  logic                   int_tick;
  logic                   sel_tick;
  logic                   at_end;
  logic                   timeout_evt;
  logic                   wr_ctrl;
  logic                   wr_stat;
  logic                   wr_mask;
  logic                   cfg_change;
  logic                   ack_wr;
  reg_byte_t              ctrl_view;
  reg_byte_t              rd_mux;

  // -----------------------------------------------------------------------------
  // Timer clock sources
  // -----------------------------------------------------------------------------
  // Internal 1 ms tick, free running
  rti_tick_div #(
    .CYCLES (TICK_CYCLES)
  ) u_tick_div (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .o_tick    (int_tick)
  );

  // External clock pin into the system domain
  rti_sync u_ext_sync (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_async   (i_ext_clk),
    .o_sync    (ext_sync)
  );

  // Rising edge history of the synchronised pin
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ext_prev_q <= 1'b0;
    end else begin
      ext_prev_q <= ext_sync;
    end
  end

  assign ext_rise = ext_sync & ~ext_prev_q;

  // RULE4 clock source choice
  assign sel_tick = clksel_q ? ext_rise : int_tick;

  // -----------------------------------------------------------------------------
  // Period lookup
  // -----------------------------------------------------------------------------
  // RULE7 internal tick counts
  // RULE8 external edge counts
  always_comb begin
    limit = `RTI_INT_CNT_1;
    case ({clksel_q, psel_q})
      4'h1:    limit = `RTI_INT_CNT_1;
      4'h2:    limit = `RTI_INT_CNT_2;
      4'h3:    limit = `RTI_INT_CNT_3;
      4'h4:    limit = `RTI_INT_CNT_4;
      4'h5:    limit = `RTI_INT_CNT_5;
      4'h6:    limit = `RTI_INT_CNT_6;
      4'h7:    limit = `RTI_INT_CNT_7;
      4'h9:    limit = `RTI_EXT_CNT_1;
      4'ha:    limit = `RTI_EXT_CNT_2;
      4'hb:    limit = `RTI_EXT_CNT_3;
      4'hc:    limit = `RTI_EXT_CNT_4;
      4'hd:    limit = `RTI_EXT_CNT_5;
      4'he:    limit = `RTI_EXT_CNT_6;
      4'hf:    limit = `RTI_EXT_CNT_7;
      default: limit = `RTI_INT_CNT_1;
    endcase
  end

  // -----------------------------------------------------------------------------
  // Register decode
  // -----------------------------------------------------------------------------
  // Write selects
  assign wr_ctrl = i_wr & (i_addr == `RTI_OFF_CTRL);
  assign wr_stat = i_wr & (i_addr == `RTI_OFF_IRQ_STAT);
  assign wr_mask = i_wr & (i_addr == `RTI_OFF_IRQ_MASK);

  // RULE2 acknowledge write
  // RULE3 zero ignored
  assign ack_wr = wr_ctrl & i_wr_data[`RTI_BIT_ACK];

  // New clock or period restarts the count
  assign cfg_change = wr_ctrl &
                      ((i_wr_data[`RTI_BIT_CLKSEL] != clksel_q) ||
                       (i_wr_data[`RTI_PSEL_HI:`RTI_PSEL_LO] != psel_q));

  // -----------------------------------------------------------------------------
  // Timer state
  // -----------------------------------------------------------------------------
  // RULE6 zero code stops the timer
  always_comb begin
    case (state_q)
      ST_OFF:  state_d = (psel_q != `RTI_PSEL_OFF) ? ST_RUN : ST_OFF;
      ST_RUN:  state_d = (psel_q == `RTI_PSEL_OFF) ? ST_OFF : ST_RUN;
      default: state_d = ST_OFF;
    endcase
  end

  // State register
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state_q <= ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // -----------------------------------------------------------------------------
  // Period counter
  // -----------------------------------------------------------------------------
  assign at_end = (cnt_q == (limit - 1'b1));

  // RULE1 end of period
  assign timeout_evt = (state_q == ST_RUN) & (psel_q != `RTI_PSEL_OFF) &
                       sel_tick & at_end & ~cfg_change;

  // RULE11 automatic restart
  // RULE9 free tick phase
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= '0;
    end else if (cfg_change || (state_q != ST_RUN) || (psel_q == `RTI_PSEL_OFF)) begin
      cnt_q <= '0;
    end else if (sel_tick) begin
      cnt_q <= at_end ? '0 : (cnt_q + 1'b1);
    end
  end

  // -----------------------------------------------------------------------------
  // Control register
  // -----------------------------------------------------------------------------
  // RULE4 clock select
  // RULE5 interrupt enable
  // RULE6 period select
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      clksel_q <= 1'(`RTI_CTRL_RESET >> `RTI_BIT_CLKSEL);
      ie_q     <= 1'(`RTI_CTRL_RESET >> `RTI_BIT_IE);
      psel_q   <= `RTI_PSEL_OFF;
    end else if (wr_ctrl) begin
      clksel_q <= i_wr_data[`RTI_BIT_CLKSEL];
      ie_q     <= i_wr_data[`RTI_BIT_IE];
      psel_q   <= i_wr_data[`RTI_PSEL_HI:`RTI_PSEL_LO];
    end
  end

  // RULE1 hardware-only set
  // RULE2 acknowledge clears, set wins
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      flag_q <= 1'b0;
    end else if (timeout_evt) begin
      flag_q <= 1'b1;
    end else if (ack_wr) begin
      flag_q <= 1'b0;
    end
  end

  // -----------------------------------------------------------------------------
  // Event status and mask
  // -----------------------------------------------------------------------------
  // Timeout and overrun events
  always_comb begin
    stat_set                   = '0;
    stat_set[`RTI_IRQ_TIMEOUT] = timeout_evt;
    stat_set[`RTI_IRQ_OVERRUN] = timeout_evt & flag_q;
  end

  // Sticky bits, write one to clear, set wins
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      stat_q <= `RTI_IRQ_RESET;
    end else begin
      stat_q <= stat_set | (stat_q & ~(wr_stat ? i_wr_data[`RTI_IRQ_W-1:0] : '0));
    end
  end

  // Mask register
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      mask_q <= `RTI_IRQ_RESET;
    end else if (wr_mask) begin
      mask_q <= i_wr_data[`RTI_IRQ_W-1:0];
    end
  end

  // -----------------------------------------------------------------------------
  // Interrupt outputs
  // -----------------------------------------------------------------------------
  // RULE10 request follows flag
  // RULE5 enable gate
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_rti_req_q <= 1'b0;
      o_irq_q     <= 1'b0;
    end else begin
      o_rti_req_q <= flag_q & ie_q;
      o_irq_q     <= |(stat_q & mask_q);
    end
  end

  // -----------------------------------------------------------------------------
  // Read path
  // -----------------------------------------------------------------------------
  // RULE3 ack reads zero
  always_comb begin
    ctrl_view                               = '0;
    ctrl_view[`RTI_BIT_FLAG]                = flag_q;
    ctrl_view[`RTI_BIT_CLKSEL]              = clksel_q;
    ctrl_view[`RTI_BIT_IE]                  = ie_q;
    ctrl_view[`RTI_PSEL_HI:`RTI_PSEL_LO]    = psel_q;
  end

  // Address mux, unmapped reads zero
  always_comb begin
    rd_mux = '0;
    case (i_addr)
      `RTI_OFF_CTRL:     rd_mux = ctrl_view;
      `RTI_OFF_IRQ_STAT: rd_mux = {{(`RTI_DATA_W-`RTI_IRQ_W){1'b0}}, stat_q};
      `RTI_OFF_IRQ_MASK: rd_mux = {{(`RTI_DATA_W-`RTI_IRQ_W){1'b0}}, mask_q};
      `RTI_OFF_CNT_LO:   rd_mux = cnt_q[7:0];
      `RTI_OFF_CNT_HI:   rd_mux = cnt_q[15:8];
      default:           rd_mux = '0;
    endcase
  end

  // Data stands for one cycle after the strobe
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_rd_data_q <= '0;
    end else begin
      o_rd_data_q <= i_rd ? rd_mux : '0;
    end
  end

  // -----------------------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------------------
  // RULE1 flag set cause
  flag_set_cause_a: assert property ( // RULE1
    @(posedge i_clk_sys) disable iff (i_rst)
    $rose(flag_q) |-> $past(timeout_evt))
    else $error("flag rose without a timeout");

  // RULE2 acknowledge effect
  ack_clears_flag_a: assert property ( // RULE2
    @(posedge i_clk_sys) disable iff (i_rst)
    (ack_wr && !timeout_evt) |=> !flag_q)
    else $error("acknowledge did not clear flag");

  // RULE3 zero acknowledge
  ack_zero_keeps_a: assert property ( // RULE3
    @(posedge i_clk_sys) disable iff (i_rst)
    (wr_ctrl && !i_wr_data[`RTI_BIT_ACK] && flag_q) |=> flag_q)
    else $error("zero acknowledge changed flag");

  // RULE3 ack bit reads zero
  ack_reads_zero_a: assert property ( // RULE3
    @(posedge i_clk_sys) disable iff (i_rst)
    (i_rd && (i_addr == `RTI_OFF_CTRL)) |=> !o_rd_data_q[`RTI_BIT_ACK])
    else $error("acknowledge bit read as one");

  // RULE4 internal clock ignores pin
  int_src_hold_a: assert property ( // RULE4
    @(posedge i_clk_sys) disable iff (i_rst)
    (!clksel_q && !int_tick && !wr_ctrl && (state_q == ST_RUN)) |=> $stable(cnt_q))
    else $error("counter moved without internal tick");

  // RULE5 enable gate
  req_gated_a: assert property ( // RULE5
    @(posedge i_clk_sys) disable iff (i_rst)
    !ie_q |=> !o_rti_req_q)
    else $error("request while disabled");

  // RULE6 disabled timer
  disabled_idle_a: assert property ( // RULE6
    @(posedge i_clk_sys) disable iff (i_rst)
    (psel_q == `RTI_PSEL_OFF) |-> (!timeout_evt ##1 (cnt_q == '0)))
    else $error("timer ran while disabled");

  // RULE7 shortest internal period
  int_period_a: assert property ( // RULE7
    @(posedge i_clk_sys) disable iff (i_rst)
    (timeout_evt && !clksel_q && (psel_q == 3'h1)) |-> (cnt_q == 16'h0007))
    else $error("wrong internal period");

  // RULE8 longest external period
  ext_period_a: assert property ( // RULE8
    @(posedge i_clk_sys) disable iff (i_rst)
    (timeout_evt && clksel_q && (psel_q == 3'h7)) |-> (cnt_q == 16'h7fff))
    else $error("wrong external period");

  // RULE10 request tracks flag
  req_follows_a: assert property ( // RULE10
    @(posedge i_clk_sys) disable iff (i_rst)
    ($fell(flag_q) ##0 !timeout_evt) |=> !o_rti_req_q)
    else $error("request stayed after flag clear");

  // RULE11 restart
  restart_zero_a: assert property ( // RULE11
    @(posedge i_clk_sys) disable iff (i_rst)
    timeout_evt |=> ((cnt_q == '0) && (state_q == ST_RUN)))
    else $error("counter did not restart");

  // Masked event line
  irq_line_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    (|(stat_q & mask_q)) |=> o_irq_q)
    else $error("interrupt line missed event");

endmodule

`default_nettype wire

/* File: dv/testbench.sv */
// Purpose: Self-checking bench for the periodic wakeup timer
// Assumes: Short internal tick (TICK_CYCLES = 4) and a slow external clock from the bench
// Notes:   Registers reached over the strobe port; timing measured in system clocks
`include "rti_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import rti_pkg::*;

  // ---------------------------------------------------------------------------
  // Signals and parameters
  // ---------------------------------------------------------------------------
  localparam int T     = 4;
  localparam int LIMIT = 80000;
  logic        clk_sys;
  logic        rst;
  reg_addr_t   addr;
  reg_byte_t   wr_data;
  logic        wr;
  logic        rd;
  reg_byte_t   rd_data;
  logic        ext_clk;
  logic        req;
  logic        irq;
  int          miscompares;
  int          cmp_count;
  int          cycles;
  int          int_ticks [7] = '{8, 32, 64, 128, 256, 512, 1024};
  int          ext_ticks [2] = '{256, 1024};

  rti_timer #(
    .TICK_CYCLES (T)
  ) i_rti_timer (
    .i_clk_sys   (clk_sys),
    .i_rst       (rst),
    .i_addr      (addr),
    .i_wr_data   (wr_data),
    .i_wr        (wr),
    .i_rd        (rd),
    .o_rd_data_q (rd_data),
    .i_ext_clk   (ext_clk),
    .o_rti_req_q (req),
    .o_irq_q     (irq)
  );

  // ---------------------------------------------------------------------------
  // Clock, cycle counter and hang guard
  // ---------------------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Cycle count doubles as time base for period checks
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      miscompares = miscompares + 1;
      $display("BAD timeout expected %0d cycles seen %0d", LIMIT, cycles);
      final_report();
    end
  end

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("BAD %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic reg_wr(input reg_addr_t a, input reg_byte_t d);
    @(posedge clk_sys);
    wr      <= 1'b1;
    addr    <= a;
    wr_data <= d;
    @(posedge clk_sys);
    wr      <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic reg_rd(input reg_addr_t a, output reg_byte_t d);
    @(posedge clk_sys);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd   <= 1'b0;
    #1;
    d = rd_data;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic wait_req(input logic lvl, input int lim);
    int n;
    n = 0;
    while (req !== lvl && n < lim) begin
      idle(1);
      n = n + 1;
    end
  endtask

  // External clock: 8 system clocks a period, well below a quarter rate
  task automatic ext_pulses(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      ext_clk <= 1'b1;
      repeat (4) @(posedge clk_sys);
      ext_clk <= 1'b0;
      repeat (3) @(posedge clk_sys);
    end
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic test_reset_and_access();
    reg_byte_t d;
    reg_rd(`RTI_OFF_CTRL, d);
    check("ctrl_reset", `RTI_CTRL_RESET, d);
    reg_rd(`RTI_OFF_IRQ_STAT, d);
    check("stat_reset", 8'h00, d);
    reg_rd(`RTI_OFF_IRQ_MASK, d);
    check("mask_reset", 8'h00, d);
    reg_rd(`RTI_OFF_CNT_LO, d);
    check("count_reset", 8'h00, d);
    reg_rd(8'h10, d);
    check("unmapped_read", 8'h00, d);
    reg_wr(8'h10, 8'hff);
    reg_wr(`RTI_OFF_CTRL, 8'hff);
    reg_rd(`RTI_OFF_CTRL, d);
    check("ctrl_rw_bits", 8'h37, d);
    reg_wr(`RTI_OFF_CTRL, 8'h00);
    reg_rd(`RTI_OFF_CTRL, d);
    check("ctrl_cleared", 8'h00, d);
    $display("test reset_and_access done");
  endtask

  task automatic test_internal_periods();
    int t0;
    int ts;
    reg_byte_t d;
    for (int c = 1; c <= 7; c++) begin
      // Clear the flag left by the previous code while switching period
      reg_wr(`RTI_OFF_CTRL, 8'h50 | c[7:0]);
      ts = cycles;
      idle(2);
      wait_req(1'b1, int_ticks[c-1] * T + 2 * T);
      check("first_timeout", 1'b1, req);
      // Period is measured from this timeout to the next one
      t0 = cycles;
      if (c == 1) begin
        check("first_short", 1'b1, (cycles - ts) >= 7 * T && (cycles - ts) <= 8 * T + 3);
        reg_wr(`RTI_OFF_CTRL, 8'h11);
        reg_rd(`RTI_OFF_CTRL, d);
        check("ack_zero_keeps", 8'h91, d);
      end
      reg_wr(`RTI_OFF_CTRL, 8'h50 | c[7:0]);
      wait_req(1'b0, 4);
      check("ack_drops_req", 1'b0, req);
      wait_req(1'b1, int_ticks[c-1] * T + 8);
      check("period_internal", int_ticks[c-1] * T, cycles - t0);
    end
    reg_wr(`RTI_OFF_CTRL, 8'h50);
    $display("test internal_periods done");
  endtask

  task automatic test_external_periods();
    for (int c = 1; c <= 2; c++) begin
      reg_wr(`RTI_OFF_CTRL, 8'h30 | c[7:0]);
      ext_pulses(ext_ticks[c-1] - 1);
      idle(10);
      check("ext_not_early", 1'b0, req);
      ext_pulses(1);
      wait_req(1'b1, 12);
      check("ext_timeout", 1'b1, req);
      reg_wr(`RTI_OFF_CTRL, 8'h50);
      wait_req(1'b0, 4);
    end
    $display("test external_periods done");
  endtask

  task automatic test_disable();
    reg_byte_t d;
    reg_wr(`RTI_OFF_CTRL, 8'h30);
    ext_pulses(300);
    idle(10);
    reg_rd(`RTI_OFF_CTRL, d);
    check("ext_code0_off", 8'h30, d);
    reg_wr(`RTI_OFF_CTRL, 8'h10);
    idle(20 * T);
    reg_rd(`RTI_OFF_CTRL, d);
    check("int_code0_off", 8'h10, d);
    check("off_no_req", 1'b0, req);
    $display("test disable done");
  endtask

  task automatic test_enable_and_events();
    reg_byte_t d;
    reg_wr(`RTI_OFF_IRQ_STAT, 8'h03);
    reg_wr(`RTI_OFF_IRQ_MASK, 8'h00);
    reg_wr(`RTI_OFF_CTRL, 8'h01);
    idle(9 * T + 4);
    check("req_gated", 1'b0, req);
    reg_rd(`RTI_OFF_CTRL, d);
    check("flag_unenabled", 8'h81, d);
    reg_rd(`RTI_OFF_IRQ_STAT, d);
    check("stat_timeout", 8'h01, d);
    check("irq_masked", 1'b0, irq);
    reg_wr(`RTI_OFF_IRQ_MASK, 8'h01);
    idle(2);
    check("irq_unmasked", 1'b1, irq);
    reg_wr(`RTI_OFF_CTRL, 8'h11);
    idle(2);
    check("req_enabled", 1'b1, req);
    idle(8 * T + 8);
    reg_rd(`RTI_OFF_IRQ_STAT, d);
    check("stat_overrun", 8'h03, d);
    reg_wr(`RTI_OFF_CTRL, 8'h50);
    reg_wr(`RTI_OFF_IRQ_STAT, 8'h03);
    idle(2);
    reg_rd(`RTI_OFF_IRQ_STAT, d);
    check("stat_w1c", 8'h00, d);
    check("irq_cleared", 1'b0, irq);
    check("req_cleared", 1'b0, req);
    reg_rd(`RTI_OFF_CTRL, d);
    check("ctrl_after_ack", 8'h10, d);
    $display("test enable_and_events done");
  endtask

  // ---------------------------------------------------------------------------
  // Verdict
  // ---------------------------------------------------------------------------
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    rst         = 1'b1;
    addr        = 8'h00;
    wr_data     = 8'h00;
    wr          = 1'b0;
    rd          = 1'b0;
    ext_clk     = 1'b0;
    miscompares = 0;
    cmp_count   = 0;
    cycles      = 0;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    test_reset_and_access();
    test_internal_periods();
    test_external_periods();
    test_disable();
    test_enable_and_events();
    final_report();
  end

endmodule

`default_nettype wire
